// File: design/lai_pkg.sv
// Package for the six-channel alarm and interrupt register set.
// Assumes one clock domain and a synchronous host register port.
package lai_pkg;

  localparam int LAI_CHANNELS = 6;
  localparam int LAI_CHAN_SHIFT = 4;

  // Register offsets inside one channel block
  localparam logic [3:0] LAI_OFF_IRQ_ENABLE = 4'h1;
  localparam logic [3:0] LAI_OFF_IRQ_FLAGS = 4'h2;
  localparam logic [3:0] LAI_OFF_ALARM_LIVE = 4'h3;
  localparam logic [3:0] LAI_OFF_TX_CONTROL = 4'h4;
  localparam logic [3:0] LAI_OFF_RX_CONTROL = 4'h5;
  localparam logic [3:0] LAI_OFF_BLOCK_CONTROL = 4'h6;
  localparam logic [3:0] LAI_OFF_JITTER_CONTROL = 4'h7;
  localparam logic [3:0] LAI_OFF_ERR_HIGH = 4'ha;
  localparam logic [3:0] LAI_OFF_ERR_LOW = 4'hb;
  localparam logic [3:0] LAI_OFF_ERR_HOLD = 4'hc;

  // Bit positions
  localparam int LAI_BIT_DRV_MON = 0;
  localparam int LAI_BIT_RX_SIG_LOSS = 1;
  localparam int LAI_BIT_RX_LOCK_LOSS = 2;
  localparam int LAI_BIT_PATTERN_ERR = 4;
  localparam int LAI_BIT_PATTERN_SAT = 5;
  localparam int LAI_BIT_ANALOG_LOSS = 4;
  localparam int LAI_BIT_DIGITAL_LOSS = 5;
  localparam int LAI_BIT_SYNC_LOSS = 6;
  localparam int LAI_BIT_ANALOG_DIS = 4;
  localparam int LAI_BIT_DIGITAL_DIS = 5;
  localparam int LAI_BIT_PATTERN_EN = 5;

  // Implemented bits per register; the rest read as zero
  localparam logic [7:0] LAI_MASK_IRQ = 8'h37;
  localparam logic [7:0] LAI_MASK_TX = 8'h37;
  localparam logic [7:0] LAI_MASK_RX = 8'h3f;
  localparam logic [7:0] LAI_MASK_BLOCK = 8'h7f;
  localparam logic [7:0] LAI_MASK_JITTER = 8'h10;

  localparam logic [7:0] LAI_CTRL_RESET = 8'h00;
  localparam logic [7:0] LAI_DRV_MON_TICKS = 8'd128;
  localparam logic [15:0] LAI_ERR_MAX = 16'hffff;

  typedef enum logic [1:0] {
    LAI_BUS_IDLE = 2'b01,
    LAI_BUS_ANSWER = 2'b10
  } lai_bus_e;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [6:0] addr;
    logic [7:0] wdata;
  } lai_bus_in_s;

  typedef struct packed {
    logic ready;
    logic data_oe;
    logic [7:0] rdata;
  } lai_bus_out_s;

  typedef struct packed {
    logic [7:0] irq_en;
    logic [7:0] tx_ctl;
    logic [7:0] rx_ctl;
    logic [7:0] blk_ctl;
    logic [7:0] jit_ctl;
  } lai_chan_ctrl_s;

  typedef struct packed {
    logic tx_tick;
    logic tx_pulse;
    logic analog_loss;
    logic digital_loss;
    logic lock_loss;
    logic pattern_in_sync;
    logic pattern_err;
  } lai_line_in_s;

  typedef struct packed {
    logic [7:0] drv_mon_cnt;
    logic [7:0] alarm;
    logic [7:0] flags;
    logic [15:0] err_count;
    logic irq;
  } lai_chan_state_s;

  typedef struct packed {
    lai_bus_e bus_state;
    lai_bus_out_s bus_out;
    lai_chan_ctrl_s [LAI_CHANNELS-1:0] ctrl;
    logic [LAI_CHANNELS-1:0][7:0] hold;
  } lai_host_state_s;

endpackage

// File: design/lai_chan.sv
// One channel: driver monitor, live alarms, sticky flags, error counter.
// Assumes line status inputs are already synchronous to ref_clk.
`timescale 1ns/100ps
module lai_chan (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input lai_pkg::lai_chan_ctrl_s ctrl,
  input lai_pkg::lai_line_in_s line,
  input wire logic flags_clr,
  output logic [7:0] alarm,
  output logic [7:0] flags,
  output logic [15:0] err_count,
  output logic irq
);
  import lai_pkg::*;

  lai_chan_state_s st;
  lai_chan_state_s next_st;

  always_comb
  begin
    logic rx_loss;
    logic pat_on;
    logic err_inc;
    logic [7:0] events;
    logic [7:0] live;
    rx_loss = 1'b0;
    pat_on = 1'b0;
    err_inc = 1'b0;
    events = 8'h00;
    live = 8'h00;
    next_st = st;
    // Pulses restart the idle count; it parks at the limit
    if (line.tx_pulse)
    begin
      next_st.drv_mon_cnt = 8'h00;
    end
    else if (line.tx_tick && st.drv_mon_cnt != LAI_DRV_MON_TICKS)
    begin
      next_st.drv_mon_cnt = st.drv_mon_cnt + 8'h01;
    end
    rx_loss = (line.analog_loss & ~ctrl.rx_ctl[LAI_BIT_ANALOG_DIS]) |
      (line.digital_loss & ~ctrl.rx_ctl[LAI_BIT_DIGITAL_DIS]);
    pat_on = ctrl.blk_ctl[LAI_BIT_PATTERN_EN];
    live[LAI_BIT_DRV_MON] = (next_st.drv_mon_cnt == LAI_DRV_MON_TICKS);
    live[LAI_BIT_RX_SIG_LOSS] = rx_loss;
    live[LAI_BIT_RX_LOCK_LOSS] = line.lock_loss;
    live[LAI_BIT_ANALOG_LOSS] = line.analog_loss;
    live[LAI_BIT_DIGITAL_LOSS] = line.digital_loss;
    live[LAI_BIT_SYNC_LOSS] = pat_on & ~line.pattern_in_sync;
    next_st.alarm = live;
    // Both edges of the monitor, signal loss and lock loss alarms count as an event
    events[LAI_BIT_DRV_MON] = live[LAI_BIT_DRV_MON] ^
      st.alarm[LAI_BIT_DRV_MON];
    events[LAI_BIT_RX_SIG_LOSS] = live[LAI_BIT_RX_SIG_LOSS] ^
      st.alarm[LAI_BIT_RX_SIG_LOSS];
    events[LAI_BIT_RX_LOCK_LOSS] = live[LAI_BIT_RX_LOCK_LOSS] ^
      st.alarm[LAI_BIT_RX_LOCK_LOSS];
    events[LAI_BIT_PATTERN_ERR] = pat_on & line.pattern_err;
    err_inc = pat_on & line.pattern_err & (st.err_count != LAI_ERR_MAX);
    if (err_inc)
    begin
      next_st.err_count = st.err_count + 16'h0001;
    end
    events[LAI_BIT_PATTERN_SAT] = err_inc &
      (st.err_count == LAI_ERR_MAX - 16'h0001);
    // Set beats the clear of a read in the same cycle
    if (flags_clr)
    begin
      next_st.flags = 8'h00;
    end
    next_st.flags = next_st.flags |
      (events & ctrl.irq_en & LAI_MASK_IRQ);
    next_st.irq = |next_st.flags;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign alarm = st.alarm;
  assign flags = st.flags;
  assign err_count = st.err_count;
  assign irq = st.irq;

endmodule // lai_chan

// File: design/lai_regs.sv
// Six-channel alarm and interrupt register set on the host parallel port.
// Assumes port strobes and line status are synchronous to ref_clk; the
// chip-level interrupt summary and the analog paths sit outside.
// Every access is answered, mapped or not, so the host never stalls.
`timescale 1ns/100ps
module lai_regs (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input lai_pkg::lai_bus_in_s bus_in,
  output lai_pkg::lai_bus_out_s bus_out,
  input lai_pkg::lai_line_in_s [lai_pkg::LAI_CHANNELS-1:0] line_in,
  output lai_pkg::lai_chan_ctrl_s [lai_pkg::LAI_CHANNELS-1:0] ctrl_out,
  output logic [lai_pkg::LAI_CHANNELS-1:0] chan_irq
);
  import lai_pkg::*;

  lai_host_state_s st;
  lai_host_state_s next_st;
  logic [LAI_CHANNELS-1:0] flags_clr;
  logic [LAI_CHANNELS-1:0][7:0] ch_alarm;
  logic [LAI_CHANNELS-1:0][7:0] ch_flags;
  logic [LAI_CHANNELS-1:0][15:0] ch_count;

  // Channel index of an address
  function automatic logic [2:0] chan_of(input logic [6:0] addr);
    chan_of = addr[6:LAI_CHAN_SHIFT];
  endfunction

  // Address hits a channel that exists
  function automatic logic chan_ok(input logic [6:0] addr);
    chan_ok = (addr[6:LAI_CHAN_SHIFT] < 3'(LAI_CHANNELS));
  endfunction

  // Writable mask of an offset; zero where nothing can be written
  function automatic logic [7:0] wr_mask(input logic [3:0] off);
    case (off)
      LAI_OFF_IRQ_ENABLE: wr_mask = LAI_MASK_IRQ;
      LAI_OFF_TX_CONTROL: wr_mask = LAI_MASK_TX;
      LAI_OFF_RX_CONTROL: wr_mask = LAI_MASK_RX;
      LAI_OFF_BLOCK_CONTROL: wr_mask = LAI_MASK_BLOCK;
      LAI_OFF_JITTER_CONTROL: wr_mask = LAI_MASK_JITTER;
      default: wr_mask = 8'h00;
    endcase
  endfunction

  // Each channel keeps its own line state and error counter
  generate
    for (genvar g = 0; g < LAI_CHANNELS; g++)
    begin : g_chan
      lai_chan u_chan (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ctrl(st.ctrl[g]),
        .line(line_in[g]),
        .flags_clr(flags_clr[g]),
        .alarm(ch_alarm[g]),
        .flags(ch_flags[g]),
        .err_count(ch_count[g]),
        .irq(chan_irq[g])
      );
    end
  endgenerate

  always_comb
  begin
    logic [2:0] ch;
    logic [3:0] off;
    logic take;
    logic hit;
    logic [7:0] rd;
    logic [7:0] wv;
    ch = 3'h0;
    off = 4'h0;
    take = 1'b0;
    hit = 1'b0;
    rd = 8'h00;
    wv = 8'h00;
    next_st = st;
    flags_clr = '0;
    ch = chan_of(bus_in.addr);
    off = bus_in.addr[3:0];
    // Channels 6 and 7 never reach the per-channel arrays
    hit = chan_ok(bus_in.addr);
    // Reserved bits are dropped here so they always read back zero
    wv = bus_in.wdata & wr_mask(off);
    take = ~bus_in.cs_n & (~bus_in.rd_n | ~bus_in.wr_n);
    case (st.bus_state)
      LAI_BUS_IDLE:
      begin
        if (take && !bus_in.rd_n)
        begin
          if (hit)
          begin
            case (off)
              LAI_OFF_IRQ_ENABLE: rd = st.ctrl[ch].irq_en;
              LAI_OFF_IRQ_FLAGS:
              begin
                rd = ch_flags[ch];
                flags_clr[ch] = 1'b1;
              end
              LAI_OFF_ALARM_LIVE: rd = ch_alarm[ch];
              LAI_OFF_TX_CONTROL: rd = st.ctrl[ch].tx_ctl;
              LAI_OFF_RX_CONTROL: rd = st.ctrl[ch].rx_ctl;
              LAI_OFF_BLOCK_CONTROL: rd = st.ctrl[ch].blk_ctl;
              LAI_OFF_JITTER_CONTROL: rd = st.ctrl[ch].jit_ctl;
              LAI_OFF_ERR_HIGH:
              begin
                // Freeze the low byte so a two-byte read is coherent
                rd = ch_count[ch][15:8];
                next_st.hold[ch] = ch_count[ch][7:0];
              end
              LAI_OFF_ERR_LOW: rd = ch_count[ch][7:0];
              LAI_OFF_ERR_HOLD: rd = st.hold[ch];
              default: rd = 8'h00;
            endcase
          end
          next_st.bus_out.rdata = rd;
          next_st.bus_out.data_oe = 1'b1;
          next_st.bus_out.ready = 1'b1;
          next_st.bus_state = LAI_BUS_ANSWER;
        end
        else if (take)
        begin
          if (hit)
          begin
            case (off)
              LAI_OFF_IRQ_ENABLE:
              begin
                next_st.ctrl[ch].irq_en = wv;
              end
              LAI_OFF_TX_CONTROL:
              begin
                next_st.ctrl[ch].tx_ctl = wv;
              end
              LAI_OFF_RX_CONTROL:
              begin
                next_st.ctrl[ch].rx_ctl = wv;
              end
              LAI_OFF_BLOCK_CONTROL:
              begin
                next_st.ctrl[ch].blk_ctl = wv;
              end
              LAI_OFF_JITTER_CONTROL:
              begin
                next_st.ctrl[ch].jit_ctl = wv;
              end
              default:
              begin
                // Read-only and unmapped offsets ignore the write
                next_st.bus_state = LAI_BUS_ANSWER;
              end
            endcase
          end
          next_st.bus_out.ready = 1'b1;
          next_st.bus_state = LAI_BUS_ANSWER;
        end
      end
      LAI_BUS_ANSWER:
      begin
        // One access per strobe; read side effects never repeat
        if (bus_in.cs_n || (bus_in.rd_n && bus_in.wr_n))
        begin
          next_st.bus_out.ready = 1'b0;
          next_st.bus_out.data_oe = 1'b0;
          next_st.bus_state = LAI_BUS_IDLE;
        end
      end
      default:
      begin
        next_st.bus_out = '0;
        next_st.bus_state = LAI_BUS_IDLE;
      end
    endcase
  end

  // Line-side state is reset inside the channel instances
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st.bus_state <= LAI_BUS_IDLE;
      st.bus_out <= '0;
      st.hold <= '0;
      for (int i = 0; i < LAI_CHANNELS; i++)
      begin
        st.ctrl[i] <= {5{LAI_CTRL_RESET}};
      end
    end
    else
    begin
      st <= next_st;
    end
  end

  assign bus_out = st.bus_out;
  assign ctrl_out = st.ctrl;

endmodule // lai_regs

// File: verification/lai_regs_monitor.sv
// Checker for the register set: port handshake and interrupt timing.
// Bound to lai_regs; one clock, synchronous active-high reset.
`timescale 1ns/100ps
module lai_regs_monitor (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input lai_pkg::lai_bus_in_s bus_in,
  input lai_pkg::lai_bus_out_s bus_out,
  input lai_pkg::lai_line_in_s [lai_pkg::LAI_CHANNELS-1:0] line_in,
  input lai_pkg::lai_chan_ctrl_s [lai_pkg::LAI_CHANNELS-1:0] ctrl_out,
  input wire logic [lai_pkg::LAI_CHANNELS-1:0] chan_irq
);
  import lai_pkg::*;
  logic req;
  assign req = !bus_in.cs_n && !(bus_in.rd_n && bus_in.wr_n);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  take_answer_a: assert property (!bus_out.ready && req
    |=> bus_out.ready)
    else $error("access not answered");
  answer_stands_a: assert property (bus_out.ready && req
    |=> bus_out.ready)
    else $error("ready dropped early");
  answer_ends_a: assert property (bus_out.ready && !req
    |=> !bus_out.ready)
    else $error("ready held after release");
  data_oe_a: assert property (bus_out.data_oe |-> bus_out.ready)
    else $error("read data without ready");
  enable_reset_a: assert property ($past(sys_rst)
    |-> ctrl_out[0].irq_en == 8'h00)
    else $error("enable not cleared by reset");
  enable_write_a: assert property ($rose(bus_out.ready) && !bus_in.wr_n
    && bus_in.rd_n && bus_in.addr == 7'h51
    |-> ctrl_out[5].irq_en == (bus_in.wdata & LAI_MASK_IRQ))
    else $error("enable write lost");
  irq_quiet_a: assert property (ctrl_out[0].irq_en == 8'h00
    && $past(ctrl_out[0].irq_en) == 8'h00 && !chan_irq[0] |=> !chan_irq[0])
    else $error("interrupt with enables clear");
  lock_enter_a: assert property ($rose(line_in[2].lock_loss)
    && ctrl_out[2].irq_en[2] |-> ##[1:3] chan_irq[2])
    else $error("lock loss not flagged");
  lock_leave_a: assert property ($fell(line_in[2].lock_loss)
    && ctrl_out[2].irq_en[2] |-> ##[1:3] chan_irq[2])
    else $error("return to lock not flagged");
  loss_change_a: assert property ($changed(line_in[3].analog_loss)
    && ctrl_out[3].irq_en[1] && !ctrl_out[3].rx_ctl[4]
    |-> ##[1:3] chan_irq[3])
    else $error("signal loss change not flagged");
  pattern_err_a: assert property (line_in[4].pattern_err
    && ctrl_out[4].irq_en[4] && ctrl_out[4].blk_ctl[5]
    |-> ##[1:3] chan_irq[4])
    else $error("pattern error not flagged");
endmodule // lai_regs_monitor

// File: verification/lai_host.sv
// Host processor model on the parallel register port.
// Assumes the set answers with ready and holds it until strobes drop.
`timescale 1ns/100ps
module lai_host (
  input wire logic ref_clk,
  input lai_pkg::lai_bus_out_s bus_out,
  output lai_pkg::lai_bus_in_s bus_in
);
  import lai_pkg::*;
  initial bus_in = '{1'b1, 1'b1, 1'b1, 7'h00, 8'h00};
  task automatic xfer(input logic rd, input logic [6:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic ok);
    int n;
    n = 0;
    @(posedge ref_clk);
    bus_in <= '{1'b0, !rd, rd, a, d};
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (bus_out.ready !== 1'b1 && n < 20);
    q = bus_out.rdata;
    // A missing answer is reported to the caller as a failed access
    ok = (bus_out.ready === 1'b1);
    // Released lines show the inverse so stale values cannot pass
    bus_in <= '{1'b1, 1'b1, 1'b1, ~a, ~d};
    @(posedge ref_clk);
  endtask
endmodule // lai_host

// File: verification/lane_alarm_interrupt_regs_bench.sv
// Bench for the six-channel alarm and interrupt register set.
// Host model owns the port; line status is driven here per channel.
`timescale 1ns/100ps
module lane_alarm_interrupt_regs_bench;
  import lai_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  lai_bus_in_s bus_in;
  lai_bus_out_s bus_out;
  lai_line_in_s [LAI_CHANNELS-1:0] line_in = '0;
  lai_chan_ctrl_s [LAI_CHANNELS-1:0] ctrl_out;
  logic [LAI_CHANNELS-1:0] chan_irq;
  logic [7:0] mask [1:7] = '{8'h37, 8'h00, 8'h00, 8'h37, 8'h3f, 8'h7f, 8'h10};
  int errors = 0;
  int total_checks = 0;
  int i;
  int c;
  lai_regs dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_in(bus_in),
    .bus_out(bus_out), .line_in(line_in), .ctrl_out(ctrl_out),
    .chan_irq(chan_irq));
  lai_host host_u (.ref_clk(ref_clk), .bus_out(bus_out), .bus_in(bus_in));
  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic ok;
    host_u.xfer(1'b0, a, d, q, ok);
    chk({7'h00, ok}, 8'h01);
  endtask
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic ok;
    host_u.xfer(1'b1, a, 8'h00, q, ok);
    chk({7'h00, ok}, 8'h01);
    chk(q, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    cyc(90000);
    errors++;
    complete_run();
  end
  initial
  begin
    cyc(6);
    sys_rst <= 1'b0;
    // Channel 6 and offsets 8, 9 are unmapped and read zero
    for (c = 0; c < 7; c++)
      for (i = 1; i < 13; i++)
        rc({c[2:0], i[3:0]}, 8'h00);
    for (c = 0; c < 6; c++)
      for (i = 1; i < 8; i++)
      begin
        wr({c[2:0], i[3:0]}, 8'hff);
        rc({c[2:0], i[3:0]}, mask[i]);
      end
    rc(7'h03, 8'h40);
    for (c = 0; c < 6; c++)
      line_in[c].pattern_in_sync <= 1'b1;
    cyc(3);
    rc(7'h03, 8'h00);
    line_in[2].lock_loss <= 1'b1;
    cyc(3);
    rc(7'h23, 8'h04);
    rc(7'h22, 8'h04);
    rc(7'h22, 8'h00);
    line_in[2].lock_loss <= 1'b0;
    cyc(3);
    rc(7'h22, 8'h04);
    wr(7'h35, 8'h00);
    wr(7'h31, 8'h00);
    line_in[3].analog_loss <= 1'b1;
    cyc(3);
    chk({7'h00, chan_irq[3]}, 8'h00);
    rc(7'h33, 8'h12);
    rc(7'h32, 8'h00);
    wr(7'h31, 8'h02);
    line_in[3].analog_loss <= 1'b0;
    cyc(3);
    chk({7'h00, chan_irq[3]}, 8'h01);
    rc(7'h32, 8'h02);
    // One tick short of the idle limit, then the last tick
    line_in[1].tx_tick <= 1'b1;
    cyc(127);
    line_in[1].tx_tick <= 1'b0;
    rc(7'h13, 8'h00);
    line_in[1].tx_tick <= 1'b1;
    cyc(1);
    line_in[1].tx_tick <= 1'b0;
    rc(7'h13, 8'h01);
    rc(7'h12, 8'h01);
    line_in[1].tx_pulse <= 1'b1;
    cyc(1);
    line_in[1].tx_pulse <= 1'b0;
    rc(7'h13, 8'h00);
    rc(7'h12, 8'h01);
    line_in[4].pattern_err <= 1'b1;
    cyc(3);
    line_in[4].pattern_err <= 1'b0;
    rc(7'h4a, 8'h00);
    rc(7'h4c, 8'h03);
    rc(7'h4b, 8'h03);
    rc(7'h42, 8'h10);
    // Long enough to pass the 16-bit ceiling
    line_in[4].pattern_err <= 1'b1;
    cyc(65540);
    line_in[4].pattern_err <= 1'b0;
    rc(7'h4a, 8'hff);
    rc(7'h4c, 8'hff);
    rc(7'h42, 8'h30);
    rc(7'h42, 8'h00);
    complete_run();
  end
endmodule // lane_alarm_interrupt_regs_bench
bind lai_regs lai_regs_monitor mon_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .bus_in(bus_in), .bus_out(bus_out), .line_in(line_in),
  .ctrl_out(ctrl_out), .chan_irq(chan_irq));
